// ==== pkg/iwc_cfg.svh ====
// Constants for the interrupt and wake-up controller.
`ifndef IWC_CFG_SVH
`define IWC_CFG_SVH
// ==========================================================
// Register map (byte addresses)
`define IWC_ADDR_CTRL     12'h000
`define IWC_ADDR_REQ      12'h004
`define IWC_ADDR_BLOCK    12'h008
`define IWC_ADDR_STATE    12'h00C
`define IWC_ADDR_VECT     12'h010
`define IWC_ADDR_IRQ_STAT 12'h014
`define IWC_ADDR_IRQ_MASK 12'h018
// ==========================================================
// Field positions
`define IWC_CTRL_GIE      0
`define IWC_CTRL_WDMODE   1
// Request bit positions
`define IWC_SRC_KEY       0
`define IWC_SRC_WDT       1
`define IWC_SRC_TMA       2
`define IWC_SRC_TMB       3
// ==========================================================
// Vectors
`define IWC_VEC_NONE      16'h0000
`define IWC_VEC_KEY       16'h0002
`define IWC_VEC_WDT_NMI   16'h0004
`define IWC_VEC_WDT_MASK  16'h0004
`define IWC_VEC_TMA       16'h0006
`define IWC_VEC_TMB       16'h0008
// ==========================================================
// Reset values
`define IWC_CTRL_RST      2'h0
`define IWC_BLOCK_RST     3'h7
`endif

// ==== pkg/iwc_pkg.sv ====
// Types shared by the interrupt and wake-up controller.
`default_nettype none
package iwc_pkg;
	typedef enum logic [1:0] {
		IWC_RUN  = 2'b00,
		IWC_HALT = 2'b01,
		IWC_STOP = 2'b10
	} iwc_mode_t;

	typedef struct packed {
		logic        valid;
		logic        nmi;
		logic [15:0] vector;
	} iwc_grant_t;
endpackage : iwc_pkg
`default_nettype wire

// ==== rtl/iwc_ctrl.sv ====
// Interrupt priority, vectoring and standby control with AXI4-Lite registers.
// Operation
// - NMI accepted even with interrupts disabled.
// - NMI bypasses and beats maskable resolver.
// - Any request asserts standby release.
// - Two NMI sources, three maskable sources.
// - Key falling edge gives NMI vector 0002H.
// - Watchdog mode 1 overflow: NMI 0004H.
// - Watchdog interval mode: maskable level 0.
// - Timer A match: maskable level 1, 0006H.
// - Timer B match: maskable level 2, 0008H.
// - Lowest priority number served first.
// - Watchdog routed to one path only.
// - Maskable accepted if unblocked, enabled and no NMI in service.
// - Key edge in STOP gives key interrupt.
// - Key detection active only in STOP.
// - Pull-ups never gate key detection.
// - HALT gates CPU clock, peripherals run.
// - STOP halts oscillator, edges wake.
//
// The register offsets and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "iwc_cfg.svh"
module iwc_ctrl (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        nrst_i,
	// AXI4-Lite slave
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [11:0] s_axi_araddr,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	// Event sources
	input  wire logic [3:0]  key_wake_inputs_i,
	input  wire logic        wdt_overflow_i,
	input  wire logic        timer_a_match_i,
	input  wire logic        timer_b_match_i,
	// CPU side
	input  wire logic        halt_cmd_i,
	input  wire logic        stop_cmd_i,
	input  wire logic        ack_i,
	input  wire logic        reti_i,
	output logic             grant_valid_o,
	output logic             grant_nmi_o,
	output logic [15:0]      grant_vector_o,
	output logic             standby_release_o,
	output logic             cpu_clk_en_o,
	output logic             osc_run_o,
	output logic             nmi_in_service_flag_o,
	output logic             irq_o
);
	// ==========================================================
	// State
	logic                global_irq_enable;
	logic                wdt_nmi_mode;
	logic [2:0]          request_block_flag;
	logic [3:0]          req;
	logic [3:0]          irq_stat;
	logic [3:0]          irq_mask;
	iwc_pkg::iwc_mode_t  mode;
	iwc_pkg::iwc_grant_t grant;
	iwc_pkg::iwc_grant_t next_grant;
	logic                key_fall;
	logic                wdt_q;
	logic                tma_q;
	logic                tmb_q;
	logic [3:0]          ev;
	logic                any_req;

	// Key edges are only armed in STOP.
	iwc_key_edge #(.W(4)) u_key (
		.clk_i             (clk_i),
		.nrst_i            (nrst_i),
		.key_wake_inputs_i (key_wake_inputs_i),
		.arm_i             (mode == iwc_pkg::IWC_STOP),
		.fall_o            (key_fall)
	);

	// ==========================================================
	// Event edges from same-clock peripherals.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wdt_q <= 1'b0;
			tma_q <= 1'b0;
			tmb_q <= 1'b0;
		end else begin
			wdt_q <= wdt_overflow_i;
			tma_q <= timer_a_match_i;
			tmb_q <= timer_b_match_i;
		end
	end

	always_comb begin
		ev                = '0;
		ev[`IWC_SRC_KEY]  = key_fall;
		ev[`IWC_SRC_WDT]  = wdt_overflow_i && !wdt_q;
		ev[`IWC_SRC_TMA]  = timer_a_match_i && !tma_q;
		ev[`IWC_SRC_TMB]  = timer_b_match_i && !tmb_q;
	end

	// ==========================================================
	// AXI4-Lite slave: both write channels taken together.
	logic        wr_go;
	logic        rd_go;
	logic [31:0] rd_val;
	logic        rd_stat;

	assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
	assign rd_go = s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'h0;
		end else begin
			s_axi_awready <= wr_go;
			s_axi_wready  <= wr_go;
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (s_axi_awaddr == `IWC_ADDR_CTRL ||
					s_axi_awaddr == `IWC_ADDR_BLOCK ||
					s_axi_awaddr == `IWC_ADDR_IRQ_MASK) ? 2'h0 : 2'h2;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_comb begin
		rd_val = 32'h0000_0000;
		unique case (s_axi_araddr)
			`IWC_ADDR_CTRL:     rd_val = {30'h0, wdt_nmi_mode, global_irq_enable};
			`IWC_ADDR_REQ:      rd_val = {28'h0, req};
			`IWC_ADDR_BLOCK:    rd_val = {29'h0, request_block_flag};
			`IWC_ADDR_STATE:    rd_val = {29'h0, nmi_in_service_flag_o, mode};
			`IWC_ADDR_VECT:     rd_val = {16'h0, grant_vector_o};
			`IWC_ADDR_IRQ_STAT: rd_val = {28'h0, irq_stat};
			`IWC_ADDR_IRQ_MASK: rd_val = {28'h0, irq_mask};
			default:            rd_val = 32'h0000_0000;
		endcase
	end

	assign rd_stat = rd_go && (s_axi_araddr == `IWC_ADDR_IRQ_STAT);

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= 2'h0;
		end else begin
			s_axi_arready <= rd_go;
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_val;
				s_axi_rresp  <= (s_axi_araddr > `IWC_ADDR_IRQ_MASK ||
					s_axi_araddr[1:0] != 2'h0) ? 2'h2 : 2'h0;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Control registers.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			{wdt_nmi_mode, global_irq_enable} <= `IWC_CTRL_RST;
			request_block_flag                <= `IWC_BLOCK_RST;
			irq_mask                          <= 4'h0;
		end else if (wr_go && s_axi_wstrb[0]) begin
			if (s_axi_awaddr == `IWC_ADDR_CTRL) begin
				global_irq_enable <= s_axi_wdata[`IWC_CTRL_GIE];
				wdt_nmi_mode      <= s_axi_wdata[`IWC_CTRL_WDMODE];
			end
			if (s_axi_awaddr == `IWC_ADDR_BLOCK) begin
				request_block_flag <= s_axi_wdata[2:0];
			end
			if (s_axi_awaddr == `IWC_ADDR_IRQ_MASK) begin
				irq_mask <= s_axi_wdata[3:0];
			end
		end
	end

	// Sticky event status, read clears, a new event wins.
	logic [3:0] next_irq_stat;
	assign next_irq_stat = (rd_stat ? 4'h0 : irq_stat) | ev;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			irq_stat <= 4'h0;
			irq_o    <= 1'b0;
		end else begin
			irq_stat <= next_irq_stat;
			irq_o    <= |(next_irq_stat & irq_mask);
		end
	end

	// ==========================================================
	// Request flags; a new event wins over acceptance clearing.
	logic [3:0] clr;
	assign clr = (ack_i && grant.valid) ? (grant.vector == `IWC_VEC_KEY ? 4'h1 :
		grant.vector == `IWC_VEC_WDT_NMI ? 4'h2 :
		grant.vector == `IWC_VEC_TMA ? 4'h4 : 4'h8) : 4'h0;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			req <= 4'h0;
		end else begin
			req <= (req & ~clr) | ev;
		end
	end

	// Priority: non-maskable first, then level 0, 1, 2.
	always_comb begin
		next_grant = '0;
		if (req[`IWC_SRC_KEY]) begin
			next_grant = '{1'b1, 1'b1, `IWC_VEC_KEY};
		end else if (req[`IWC_SRC_WDT] && wdt_nmi_mode) begin
			next_grant = '{1'b1, 1'b1, `IWC_VEC_WDT_NMI};
		end else if (global_irq_enable && !nmi_in_service_flag_o) begin
			if (req[`IWC_SRC_WDT] && !wdt_nmi_mode && !request_block_flag[0]) begin
				next_grant = '{1'b1, 1'b0, `IWC_VEC_WDT_MASK};
			end else if (req[`IWC_SRC_TMA] && !request_block_flag[1]) begin
				next_grant = '{1'b1, 1'b0, `IWC_VEC_TMA};
			end else if (req[`IWC_SRC_TMB] && !request_block_flag[2]) begin
				next_grant = '{1'b1, 1'b0, `IWC_VEC_TMB};
			end
		end
	end

	// Blocked requests still wake the core but are not vectored.
	assign any_req = |req;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			grant <= '0;
		end else begin
			grant <= next_grant;
		end
	end

	assign grant_valid_o  = grant.valid;
	assign grant_nmi_o    = grant.nmi;
	assign grant_vector_o = grant.vector;

	// ==========================================================
	// Standby and in-service state.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			mode              <= iwc_pkg::IWC_RUN;
			standby_release_o <= 1'b0;
			cpu_clk_en_o      <= 1'b1;
			osc_run_o         <= 1'b1;
		end else begin
			standby_release_o <= any_req;
			unique case (mode)
				iwc_pkg::IWC_RUN: begin
					if (stop_cmd_i) begin
						mode         <= iwc_pkg::IWC_STOP;
						cpu_clk_en_o <= 1'b0;
						osc_run_o    <= 1'b0;
					end else if (halt_cmd_i) begin
						mode         <= iwc_pkg::IWC_HALT;
						cpu_clk_en_o <= 1'b0;
					end
				end
				default: begin
					if (any_req) begin
						mode         <= iwc_pkg::IWC_RUN;
						cpu_clk_en_o <= 1'b1;
						osc_run_o    <= 1'b1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			nmi_in_service_flag_o <= 1'b0;
		end else if (ack_i && grant.valid && grant.nmi) begin
			nmi_in_service_flag_o <= 1'b1;
		end else if (reti_i) begin
			nmi_in_service_flag_o <= 1'b0;
		end
	end

	// ==========================================================
	// Checks.
	chk_nmi_no_gate: assert property (@(posedge clk_i) disable iff (!nrst_i)
		req[0] |=> grant_valid_o && grant_nmi_o)
		else $error("key nmi not granted");
	chk_nmi_wins: assert property (@(posedge clk_i) disable iff (!nrst_i)
		((req[0] || (req[1] && wdt_nmi_mode)) && |req[3:2]) |=> grant_valid_o && grant_nmi_o)
		else $error("nmi lost");
	chk_release: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(|req) |=> standby_release_o)
		else $error("no standby release");
	chk_key_req: assert property (@(posedge clk_i) disable iff (!nrst_i)
		key_fall |=> req[0])
		else $error("key edge lost");
	chk_wdt_nmi_vec: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(req[1] && wdt_nmi_mode && !req[0]) |=> grant_nmi_o && grant_vector_o == 16'h0004)
		else $error("wdt nmi vector");
	chk_wdt_route: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(grant_valid_o && grant_vector_o == 16'h0004) |-> grant_nmi_o == $past(wdt_nmi_mode))
		else $error("watchdog path");
	chk_tma_vec: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(grant_valid_o && !grant_nmi_o && grant_vector_o == 16'h0006) |-> $past(req[2]))
		else $error("timer a vector");
	chk_tmb_vec: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(grant_valid_o && !grant_nmi_o && grant_vector_o == 16'h0008) |-> $past(req[3]))
		else $error("timer b vector");
	chk_prio_order: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(req[2] && req[3] && !req[1] && !req[0] && global_irq_enable
		&& !nmi_in_service_flag_o && request_block_flag == 3'h0 && !(ack_i && grant.valid))
		|=> grant_vector_o == 16'h0006) else $error("priority order");
	chk_mask_gate: assert property (@(posedge clk_i) disable iff (!nrst_i)
		!global_irq_enable |=> !(grant_valid_o && !grant_nmi_o))
		else $error("gie ignored");
	chk_key_armed: assert property (@(posedge clk_i) disable iff (!nrst_i)
		key_fall |-> $past(mode == iwc_pkg::IWC_STOP))
		else $error("key outside stop");
	chk_halt_clk: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(mode == iwc_pkg::IWC_HALT) |-> !cpu_clk_en_o && osc_run_o)
		else $error("halt clocks");
	chk_stop_clk: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(mode == iwc_pkg::IWC_STOP) |-> !cpu_clk_en_o && !osc_run_o)
		else $error("stop clocks");
	chk_wake_run: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(mode != iwc_pkg::IWC_RUN && any_req) |=> mode == iwc_pkg::IWC_RUN && cpu_clk_en_o)
		else $error("no wake from standby");
	chk_svc_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(nmi_in_service_flag_o && !reti_i) |=> nmi_in_service_flag_o)
		else $error("in service flag drop");
endmodule : iwc_ctrl
`default_nettype wire

// ==== rtl/iwc_key_edge.sv ====
// Key wake input synchroniser and falling-edge detector.
`timescale 1ns/1ps
`default_nettype none
module iwc_key_edge #(
	parameter int W = 4
) (
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         nrst_i,
	// Pins and gating
	input  wire logic [W-1:0] key_wake_inputs_i,
	input  wire logic         arm_i,
	output logic              fall_o
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;
	logic [W-1:0] level;
	logic [W-1:0] next_level;

	// ==========================================================
	// Three stages; a change counts when stages two and three agree.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s1 <= '1;
			s2 <= '1;
			s3 <= '1;
		end else begin
			s1 <= key_wake_inputs_i;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// A pin takes a new level only once stages two and three agree, so a glitch
	// that reaches stage two alone is never counted as an edge.
	assign next_level = (level & (s2 ^ s3)) | (s3 & ~(s2 ^ s3));

	// All four pins always feed the detector, pull-up choice aside.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			level  <= '1;
			fall_o <= 1'b0;
		end else begin
			level  <= next_level;
			fall_o <= arm_i && |(level & ~next_level);
		end
	end
endmodule : iwc_key_edge
`default_nettype wire

// ==== verification/iwc_cpu_model.sv ====
// Behavioural CPU core that accepts grants and returns from NMI handlers.
`timescale 1ns/1ps
`default_nettype none
module iwc_cpu_model (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       nrst_i,
	// Grant from the controller, accept latency from the bench
	input  wire logic       grant_valid_i,
	input  wire logic       grant_nmi_i,
	input  wire logic [1:0] lat_i,
	// Core answers
	output logic            ack_o,
	output logic            reti_o
);
	// =====
	// Accept and return.
	// A served grant stays visible for two more edges, so the core pauses.
	int wait_n;
	int hold_n;
	int svc_n;
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ack_o  <= 1'h0;
			reti_o <= 1'h0;
			wait_n <= 0;
			hold_n <= 0;
			svc_n  <= 0;
		end else begin
			ack_o  <= 1'h0;
			reti_o <= 1'h0;
			if (svc_n > 1) svc_n <= svc_n - 1;
			else if (svc_n == 1) begin
				reti_o <= 1'h1;
				svc_n  <= 0;
			end
			if (hold_n > 0) hold_n <= hold_n - 1;
			else if (grant_valid_i) begin
				if (wait_n < int'(lat_i)) wait_n <= wait_n + 1;
				else begin
					ack_o  <= 1'h1;
					wait_n <= 0;
					hold_n <= 3;
					if (grant_nmi_i) svc_n <= 5;
				end
			end
		end
	end
endmodule : iwc_cpu_model
`default_nettype wire

// ==== verification/iwc_ctrl_tb.sv ====
// Self-checking bench for the interrupt and wake-up controller.
`timescale 1ns/1ps
`default_nettype none
`include "iwc_cfg.svh"
module iwc_ctrl_tb;
	logic        clk_i, nrst_i, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, wdt, tma, tmb, halt, stop, ack, reti;
	logic        gvalid, gnmi, standby, clk_en, osc, in_svc, irq, nmi_seen, reti_seen;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [15:0] gvec;
	logic [7:0]  seed;
	logic [3:0]  key;
	logic [1:0]  bresp, rresp, lat;
	logic [16:0] gq[$];
	logic [33:0] rq[$];
	int          errors, cmp_count, n;

	initial begin
		clk_i = 1'h0;
		forever #2.5 clk_i = ~clk_i;
	end

	iwc_ctrl i_iwc_ctrl (.clk_i(clk_i), .nrst_i(nrst_i),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'h1), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .key_wake_inputs_i(key),
		.wdt_overflow_i(wdt), .timer_a_match_i(tma), .timer_b_match_i(tmb),
		.halt_cmd_i(halt), .stop_cmd_i(stop), .ack_i(ack), .reti_i(reti),
		.grant_valid_o(gvalid), .grant_nmi_o(gnmi), .grant_vector_o(gvec),
		.standby_release_o(standby), .cpu_clk_en_o(clk_en), .osc_run_o(osc),
		.nmi_in_service_flag_o(in_svc), .irq_o(irq));

	iwc_cpu_model i_iwc_cpu_model (.clk_i(clk_i), .nrst_i(nrst_i), .grant_valid_i(gvalid),
		.grant_nmi_i(gnmi), .lat_i(lat), .ack_o(ack), .reti_o(reti));

	// =====
	// Shared tasks.
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check

	task automatic test_done;
		$display("Comparisons %0d, mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : test_done

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_i);
		awvalid <= 1'h1;
		wvalid  <= 1'h1;
		awaddr  <= a;
		wdata   <= d;
		bready  <= 1'h1;
		do begin
			@(posedge clk_i);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end while (bvalid !== 1'h1);
		bready <= 1'h0;
		check(bresp, 2'h0);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [33:0] e);
		rq.push_back(e);
		@(posedge clk_i);
		arvalid <= 1'h1;
		araddr  <= a;
		rready  <= 1'h1;
		do begin
			@(posedge clk_i);
			if (arready) arvalid <= 1'h0;
		end while (rvalid !== 1'h1);
		rready <= 1'h0;
	endtask : rd

	task automatic ev(input logic [2:0] m);
		@(posedge clk_i);
		{wdt, tma, tmb} <= m;
		@(posedge clk_i);
		{wdt, tma, tmb} <= 3'h0;
	endtask : ev

	// Waits for every noted grant and the end of any handler; retimes the core.
	task automatic drain;
		for (n = 0; n < 300 && (gq.size() != 0 || in_svc !== 1'h0); n++) @(negedge clk_i);
		check(n < 300, 1'h1);
		seed = lfsr(seed);
		lat <= seed[1:0];
		repeat (4) @(posedge clk_i);
	endtask : drain

	// =====
	// Result watchers.
	always @(posedge clk_i) begin
		if (ack === 1'h1 && gvalid === 1'h1)
			check({gnmi, gvec}, gq.size() ? gq.pop_front() : 17'h1FFFF);
		if (rvalid === 1'h1 && rready === 1'h1)
			check({rresp, rdata}, rq.size() ? rq.pop_front() : 34'h3FFFFFFFF);
		if (nmi_seen) check(in_svc, 1'h1);
		if (reti_seen) check(in_svc, 1'h0);
		nmi_seen  <= ack && gvalid && gnmi;
		reti_seen <= reti;
	end

	initial begin
		repeat (6000) @(posedge clk_i);
		errors++;
		test_done();
	end

	// =====
	// Main sequence.
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, nmi_seen, reti_seen} = 7'h0;
		{awaddr, araddr, wdata} = 56'h0;
		{wdt, tma, tmb, halt, stop, nrst_i} = 6'h0;
		key = 4'hF;
		lat = 2'h0;
		seed = 8'h4C;
		errors = 0;
		cmp_count = 0;
		repeat (10) @(posedge clk_i);
		nrst_i <= 1'h1;
		rd(`IWC_ADDR_CTRL, 34'h0);
		rd(`IWC_ADDR_BLOCK, 34'h7);
		rd(`IWC_ADDR_IRQ_STAT, 34'h0);
		rd(12'h01C, {2'h2, 32'h0});
		wr(`IWC_ADDR_IRQ_MASK, 32'h4);
		ev(3'h2);
		repeat (4) @(posedge clk_i);
		check({standby, gvalid, irq}, 3'h5);
		rd(`IWC_ADDR_REQ, 34'h4);
		rd(`IWC_ADDR_IRQ_STAT, 34'h4);
		repeat (2) @(posedge clk_i);
		check(irq, 1'h0);
		wr(`IWC_ADDR_CTRL, 32'h2);
		gq.push_back({1'h1, 16'h0004});
		ev(3'h4);
		drain();
		wr(`IWC_ADDR_BLOCK, 32'h0);
		repeat (6) @(posedge clk_i);
		check(gvalid, 1'h0);
		gq.push_back({1'h0, 16'h0006});
		wr(`IWC_ADDR_CTRL, 32'h3);
		drain();
		// All three maskable sources at once, then a non-maskable one against one.
		wr(`IWC_ADDR_CTRL, 32'h1);
		gq.push_back({1'h0, 16'h0004});
		gq.push_back({1'h0, 16'h0006});
		gq.push_back({1'h0, 16'h0008});
		ev(3'h7);
		drain();
		wr(`IWC_ADDR_CTRL, 32'h3);
		gq.push_back({1'h1, 16'h0004});
		gq.push_back({1'h0, 16'h0006});
		ev(3'h6);
		drain();
		rd(`IWC_ADDR_REQ, 34'h0);
		// Each key pin, first outside and then inside STOP.
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_i);
			key <= 4'hF ^ (4'h1 << i);
			repeat (8) @(posedge clk_i);
			key <= 4'hF;
			rd(`IWC_ADDR_REQ, 34'h0);
			gq.push_back({1'h1, 16'h0002});
			stop <= 1'h1;
			@(posedge clk_i);
			stop <= 1'h0;
			repeat (3) @(posedge clk_i);
			check({osc, clk_en}, 2'h0);
			key <= 4'hF ^ (4'h1 << i);
			drain();
			check({osc, clk_en}, 2'h3);
			key <= 4'hF;
		end
		// A blocked request still ends HALT.
		wr(`IWC_ADDR_BLOCK, 32'h7);
		halt <= 1'h1;
		@(posedge clk_i);
		halt <= 1'h0;
		repeat (3) @(posedge clk_i);
		check({osc, clk_en}, 2'h2);
		ev(3'h1);
		repeat (6) @(posedge clk_i);
		check({standby, clk_en, gvalid}, 3'h6);
		gq.push_back({1'h0, 16'h0008});
		wr(`IWC_ADDR_BLOCK, 32'h0);
		drain();
		test_done();
	end
endmodule : iwc_ctrl_tb
`default_nettype wire
